// [hdl/dbo_out_ctrl.sv]
// Purpose: Converter output side, pairs samples onto two half-rate buses
// Assumes: SAMPLE_IN carries one offset-binary conversion per MCLK
// Notes:   Link pins from the capture end pass a three-stage synchroniser
//
// Summary of operation
// - Two 12-bit buses, each at half rate
// - Default sample format is twos complement
// - Drive data-ready strobes beside the buses
// - Load configuration automatically after power-up
// - Reload low parks strobes and data high
// - Capture end holds reload low 200 ns
// - Reload starts on the reload rising edge
// - Reload finishes within 600 ms
// - Resumed strobe toggling marks reload complete
// - Async sync low held at least 5 ns; the synchroniser filters lows under two MCLK cycles (20 ns)
// - Sync low stops both strobes
// - Strobes restart together at next bus A word
// - Unused sync input is held high
// - Encode clock divided by two, both strobes in phase
`timescale 1ns/1ns
`default_nettype none
module dbo_out_ctrl #(
    parameter int CFG_LOAD_CYCLES = dbo_pkg::RELOAD_MAX_CYCLES  // Load time, within limit
) (
    input  wire logic                      MCLK,
    input  wire logic                      RST_B,
    input  wire logic [dbo_pkg::SMP_W-1:0] SAMPLE_IN,
    input  wire logic                      FORMAT_OFFSET,
    output logic                           CFG_READY,
    dbo_link_if.dev                        LINK
);
    typedef enum logic [1:0] {
        DBO_LOAD,
        DBO_HELD,
        DBO_RUN
    } dbo_state_e;

    localparam logic [dbo_pkg::CNT_W-1:0] LOAD_LAST =
        dbo_pkg::CNT_W'(CFG_LOAD_CYCLES - 1);

    // Converter codes arrive offset binary; flipping the sign bit gives twos complement
    function automatic logic [dbo_pkg::SMP_W-1:0] dbo_format(
        input logic [dbo_pkg::SMP_W-1:0] code,
        input logic                      offset
    );
        logic [dbo_pkg::SMP_W-1:0] res;
        res = code;
        if (!offset) begin
            res[dbo_pkg::SMP_W-1] = ~code[dbo_pkg::SMP_W-1];
        end
        return res;
    endfunction

    logic [dbo_pkg::SYNC_STAGES-1:0] reload_pipe;
    logic [dbo_pkg::SYNC_STAGES-1:0] next_reload_pipe;
    logic [dbo_pkg::SYNC_STAGES-1:0] hold_pipe;
    logic [dbo_pkg::SYNC_STAGES-1:0] next_hold_pipe;
    logic                            reload_lvl;
    logic                            next_reload_lvl;
    logic                            hold_lvl;
    logic                            next_hold_lvl;

    dbo_state_e                state;
    dbo_state_e                next_state;
    logic [dbo_pkg::CNT_W-1:0] count;
    logic [dbo_pkg::CNT_W-1:0] next_count;
    logic                      phase;
    logic                      next_phase;
    logic [dbo_pkg::SMP_W-1:0] early;
    logic [dbo_pkg::SMP_W-1:0] next_early;
    logic [dbo_pkg::SMP_W-1:0] bus_a;
    logic [dbo_pkg::SMP_W-1:0] next_bus_a;
    logic [dbo_pkg::SMP_W-1:0] bus_b;
    logic [dbo_pkg::SMP_W-1:0] next_bus_b;
    logic                      stb_a;
    logic                      next_stb_a;
    logic                      stb_b;
    logic                      next_stb_b;
    logic                      ready;
    logic                      next_ready;

    // Pin synchronisers; a level only counts once stages two and three agree
    always_comb begin
        next_reload_pipe = {reload_pipe[dbo_pkg::SYNC_STAGES-2:0], LINK.reload_n};
        next_hold_pipe   = {hold_pipe[dbo_pkg::SYNC_STAGES-2:0], LINK.capture_sync_hold_n};
        next_reload_lvl  = reload_lvl;
        next_hold_lvl    = hold_lvl;
        if (reload_pipe[1] == reload_pipe[2]) begin
            next_reload_lvl = reload_pipe[2];
        end
        // Lows shorter than two cycles are filtered; the capture end holds far longer
        if (hold_pipe[1] == hold_pipe[2]) begin
            next_hold_lvl = hold_pipe[2];
        end
    end

    // Idle level of both pins is high
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            reload_pipe <= dbo_pkg::PIPE_IDLE;
            hold_pipe   <= dbo_pkg::PIPE_IDLE;
            reload_lvl  <= 1'b1;
            hold_lvl    <= 1'b1;
        end else begin
            reload_pipe <= next_reload_pipe;
            hold_pipe   <= next_hold_pipe;
            reload_lvl  <= next_reload_lvl;
            hold_lvl    <= next_hold_lvl;
        end
    end

    // Load sequencer and half-rate output pairing
    always_comb begin
        next_state = state;
        next_count = count;
        next_phase = phase;
        next_early = early;
        next_bus_a = bus_a;
        next_bus_b = bus_b;
        next_stb_a = stb_a;
        next_stb_b = stb_b;
        next_ready = ready;
        case (state)
            DBO_LOAD: begin
                next_bus_a = dbo_pkg::BUS_PARKED;
                next_bus_b = dbo_pkg::BUS_PARKED;
                next_stb_a = 1'b1;
                next_stb_b = 1'b1;
                next_ready = 1'b0;
                if (!reload_lvl) begin
                    next_state = DBO_HELD;
                    next_count = dbo_pkg::CNT_ZERO;
                end else if (count == LOAD_LAST) begin
                    // Load time is a parameter bounded by the longest reload
                    next_state = DBO_RUN;
                    next_count = dbo_pkg::CNT_ZERO;
                    next_phase = 1'b0;
                    next_ready = 1'b1;
                end else begin
                    next_count = count + dbo_pkg::CNT_ONE;
                end
            end
            DBO_HELD: begin
                next_bus_a = dbo_pkg::BUS_PARKED;
                next_bus_b = dbo_pkg::BUS_PARKED;
                next_stb_a = 1'b1;
                next_stb_b = 1'b1;
                next_ready = 1'b0;
                next_count = dbo_pkg::CNT_ZERO;
                // Nothing reloads while the pin is low, only on its release
                if (reload_lvl) begin
                    next_state = DBO_LOAD;
                end
            end
            DBO_RUN: begin
                if (!reload_lvl) begin
                    next_state = DBO_HELD;
                    next_ready = 1'b0;
                    next_bus_a = dbo_pkg::BUS_PARKED;
                    next_bus_b = dbo_pkg::BUS_PARKED;
                    next_stb_a = 1'b1;
                    next_stb_b = 1'b1;
                end else begin
                    // Divide by two: even cycles feed the early slot, odd ones the late
                    next_phase = ~phase;
                    if (!phase) begin
                        next_early = dbo_format(SAMPLE_IN, FORMAT_OFFSET);
                    end else begin
                        next_bus_a = early;
                        next_bus_b = dbo_format(SAMPLE_IN, FORMAT_OFFSET);
                        // Strobes move only at a word boundary, so after a hold they
                        // always come back together on a fresh bus A word
                        if (hold_lvl) begin
                            next_stb_a = ~stb_a;
                            next_stb_b = ~stb_b;
                        end
                    end
                end
            end
            default: begin
                next_state = DBO_LOAD;
            end
        endcase
    end

    // Reset acts as power-up: the configuration load starts by itself
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= DBO_LOAD;
            count <= dbo_pkg::CNT_ZERO;
            phase <= 1'b0;
            early <= '0;
            bus_a <= dbo_pkg::BUS_PARKED;
            bus_b <= dbo_pkg::BUS_PARKED;
            stb_a <= 1'b1;
            stb_b <= 1'b1;
            ready <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            phase <= next_phase;
            early <= next_early;
            bus_a <= next_bus_a;
            bus_b <= next_bus_b;
            stb_a <= next_stb_a;
            stb_b <= next_stb_b;
            ready <= next_ready;
        end
    end

    // All link outputs come straight from flip-flops
    assign LINK.bus_a          = bus_a;
    assign LINK.bus_b          = bus_b;
    assign LINK.ready_strobe_a = stb_a;
    assign LINK.ready_strobe_b = stb_b;
    assign CFG_READY           = ready;
endmodule
`default_nettype wire

// [hdl/dbo_pkg.sv]
// Purpose: Shared constants for the dual-bus sample output link
// Assumes: One 100 MHz clock drives both ends of the link
// Notes:   Time figures are kept in their own unit and converted to cycles here
package dbo_pkg;
    localparam int SMP_W          = 12;          // Width of each output bus
    localparam int CNT_W          = 26;          // Wide enough for the reload limit
    localparam int SYNC_STAGES    = 3;           // Pin synchroniser depth
    localparam int CLK_PERIOD_NS  = 10;          // MCLK period
    localparam int RELOAD_HOLD_NS = 200;         // Least low time of the reload pin
    localparam int RELOAD_MAX_MS  = 600;         // Longest configuration reload
    localparam int SYNC_LOW_NS    = 5;           // Least low time of the sync pin
    localparam int NS_PER_MS      = 1000000;
    // Least times round up, longest times round down
    localparam int RELOAD_HOLD_CYCLES =
        (RELOAD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELOAD_MAX_CYCLES  = RELOAD_MAX_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int SYNC_LOW_CYCLES    =
        (SYNC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [SMP_W-1:0] BUS_PARKED = {SMP_W{1'b1}};  // Level while reloading
    localparam logic [SYNC_STAGES-1:0] PIPE_IDLE = {SYNC_STAGES{1'b1}};
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
endpackage

// [hdl/dbo_link_if.sv]
// Purpose: Pins between the converter output logic and the capture logic
// Assumes: Every pin is driven by exactly one end, no two-way pins
// Notes:   No clocking block; both ends run on the same MCLK
`timescale 1ns/1ns
`default_nettype none
interface dbo_link_if;
    logic [dbo_pkg::SMP_W-1:0] bus_a;                // Earlier sample of each pair
    logic [dbo_pkg::SMP_W-1:0] bus_b;                // Later sample of each pair
    logic                      ready_strobe_a;
    logic                      ready_strobe_b;
    logic                      reload_n;             // Low parks outputs, rise reloads
    logic                      capture_sync_hold_n;  // Low stops both strobes

    // Converter output end
    modport dev (
        output bus_a,
        output bus_b,
        output ready_strobe_a,
        output ready_strobe_b,
        input  reload_n,
        input  capture_sync_hold_n
    );
    // Capture logic end
    modport cap (
        input  bus_a,
        input  bus_b,
        input  ready_strobe_a,
        input  ready_strobe_b,
        output reload_n,
        output capture_sync_hold_n
    );
endinterface
`default_nettype wire

// [hdl/dbo_capture.sv]
// Purpose: Capture end, collects word pairs and drives reload and sync pins
// Assumes: Link inputs come from outside this domain and are synchronised
// Notes:   A pair is reported only once both strobes have moved
`timescale 1ns/1ns
`default_nettype none
module dbo_capture #(
    parameter int RELOAD_LIMIT_CYCLES = dbo_pkg::RELOAD_MAX_CYCLES  // Reload timeout
) (
    input  wire logic                      MCLK,
    input  wire logic                      RST_B,
    input  wire logic                      RELOAD_REQ,
    input  wire logic                      SYNC_HOLD,
    output logic [dbo_pkg::SMP_W-1:0]      PAIR_A,
    output logic [dbo_pkg::SMP_W-1:0]      PAIR_B,
    output logic                           PAIR_VALID,
    output logic                           LINK_UP,
    output logic                           RELOAD_TIMEOUT,
    dbo_link_if.cap                        LINK
);
    typedef enum logic [1:0] {
        DBC_PULSE,
        DBC_WAIT,
        DBC_UP
    } dbc_state_e;

    localparam logic [dbo_pkg::CNT_W-1:0] HOLD_LAST =
        dbo_pkg::CNT_W'(dbo_pkg::RELOAD_HOLD_CYCLES - 1);
    localparam logic [dbo_pkg::CNT_W-1:0] LIMIT_LAST =
        dbo_pkg::CNT_W'(RELOAD_LIMIT_CYCLES - 1);

    logic [dbo_pkg::SYNC_STAGES-1:0] sa_pipe;
    logic [dbo_pkg::SYNC_STAGES-1:0] sb_pipe;
    logic [dbo_pkg::SMP_W-1:0]       a_pipe [dbo_pkg::SYNC_STAGES];
    logic [dbo_pkg::SMP_W-1:0]       b_pipe [dbo_pkg::SYNC_STAGES];
    logic                            ev_a;
    logic                            ev_b;
    logic [dbo_pkg::SYNC_STAGES-1:0] next_sa_pipe;
    logic [dbo_pkg::SYNC_STAGES-1:0] next_sb_pipe;
    logic [dbo_pkg::SMP_W-1:0]       next_a_pipe [dbo_pkg::SYNC_STAGES];
    logic [dbo_pkg::SMP_W-1:0]       next_b_pipe [dbo_pkg::SYNC_STAGES];

    dbc_state_e                state;
    dbc_state_e                next_state;
    logic [dbo_pkg::CNT_W-1:0] count;
    logic [dbo_pkg::CNT_W-1:0] next_count;
    logic                      seen_a;
    logic                      next_seen_a;
    logic                      seen_b;
    logic                      next_seen_b;
    logic                      got_a;
    logic                      next_got_a;
    logic                      got_b;
    logic                      next_got_b;
    logic [dbo_pkg::SMP_W-1:0] pair_a;
    logic [dbo_pkg::SMP_W-1:0] next_pair_a;
    logic [dbo_pkg::SMP_W-1:0] pair_b;
    logic [dbo_pkg::SMP_W-1:0] next_pair_b;
    logic                      pair_vld;
    logic                      next_pair_vld;
    logic                      timeout;
    logic                      next_timeout;
    logic                      sync_n;
    logic                      next_sync_n;

    // Three-stage pin synchronisers for strobes and data alike
    always_comb begin
        next_sa_pipe   = {sa_pipe[dbo_pkg::SYNC_STAGES-2:0], LINK.ready_strobe_a};
        next_sb_pipe   = {sb_pipe[dbo_pkg::SYNC_STAGES-2:0], LINK.ready_strobe_b};
        next_a_pipe[0] = LINK.bus_a;
        next_b_pipe[0] = LINK.bus_b;
        for (int i = 1; i < dbo_pkg::SYNC_STAGES; i++) begin
            next_a_pipe[i] = a_pipe[i-1];
            next_b_pipe[i] = b_pipe[i-1];
        end
    end

    // Reset to the parked levels, so no false strobe edge follows reset
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sa_pipe <= dbo_pkg::PIPE_IDLE;
            sb_pipe <= dbo_pkg::PIPE_IDLE;
            for (int i = 0; i < dbo_pkg::SYNC_STAGES; i++) begin
                a_pipe[i] <= dbo_pkg::BUS_PARKED;
                b_pipe[i] <= dbo_pkg::BUS_PARKED;
            end
        end else begin
            sa_pipe <= next_sa_pipe;
            sb_pipe <= next_sb_pipe;
            a_pipe  <= next_a_pipe;
            b_pipe  <= next_b_pipe;
        end
    end

    // A strobe change counts once stages two and three agree on the new level
    assign ev_a = (sa_pipe[1] == sa_pipe[2]) && (sa_pipe[2] != seen_a);
    assign ev_b = (sb_pipe[1] == sb_pipe[2]) && (sb_pipe[2] != seen_b);

    // Reload pulse, completion watch and pair assembly
    always_comb begin
        next_state    = state;
        next_count    = count;
        next_seen_a   = ev_a ? sa_pipe[2] : seen_a;
        next_seen_b   = ev_b ? sb_pipe[2] : seen_b;
        next_got_a    = got_a | ev_a;
        next_got_b    = got_b | ev_b;
        next_pair_a   = pair_a;
        next_pair_b   = pair_b;
        next_pair_vld = 1'b0;
        next_timeout  = timeout;
        next_sync_n   = ~SYNC_HOLD;
        if (ev_a) begin
            next_pair_a = a_pipe[2];
        end
        if (ev_b) begin
            next_pair_b = b_pipe[2];
        end
        case (state)
            DBC_PULSE: begin
                // Strobes jump high while parked; that is no data word
                next_got_a = 1'b0;
                next_got_b = 1'b0;
                if (count == HOLD_LAST) begin
                    next_state = DBC_WAIT;
                    next_count = dbo_pkg::CNT_ZERO;
                end else begin
                    next_count = count + dbo_pkg::CNT_ONE;
                end
            end
            DBC_WAIT: begin
                if (ev_a || ev_b) begin
                    next_state = DBC_UP;
                    next_got_a = 1'b0;
                    next_got_b = 1'b0;
                end else if (count == LIMIT_LAST) begin
                    next_timeout = 1'b1;
                end else begin
                    next_count = count + dbo_pkg::CNT_ONE;
                end
            end
            DBC_UP: begin
                if (next_got_a && next_got_b) begin
                    next_pair_vld = 1'b1;
                    next_got_a    = 1'b0;
                    next_got_b    = 1'b0;
                end
            end
            default: begin
                next_state = DBC_WAIT;
            end
        endcase
        // A new request restarts the pulse from any state
        if (RELOAD_REQ) begin
            next_state   = DBC_PULSE;
            next_count   = dbo_pkg::CNT_ZERO;
            next_timeout = 1'b0;
        end
    end

    // After reset the device is loading, so the first strobe move means ready
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state    <= DBC_WAIT;
            count    <= dbo_pkg::CNT_ZERO;
            seen_a   <= 1'b1;
            seen_b   <= 1'b1;
            got_a    <= 1'b0;
            got_b    <= 1'b0;
            pair_a   <= '0;
            pair_b   <= '0;
            pair_vld <= 1'b0;
            timeout  <= 1'b0;
            sync_n   <= 1'b1;
        end else begin
            state    <= next_state;
            count    <= next_count;
            seen_a   <= next_seen_a;
            seen_b   <= next_seen_b;
            got_a    <= next_got_a;
            got_b    <= next_got_b;
            pair_a   <= next_pair_a;
            pair_b   <= next_pair_b;
            pair_vld <= next_pair_vld;
            timeout  <= next_timeout;
            sync_n   <= next_sync_n;
        end
    end

    assign LINK.reload_n            = (state != DBC_PULSE);
    assign LINK.capture_sync_hold_n = sync_n;
    assign PAIR_A                   = pair_a;
    assign PAIR_B                   = pair_b;
    assign PAIR_VALID               = pair_vld;
    assign LINK_UP                  = (state == DBC_UP);
    assign RELOAD_TIMEOUT           = timeout;
endmodule
`default_nettype wire

// [sim/dbo_link_properties.sv]
// Purpose: Timing properties of the sample output link pins
// Assumes: Both ends share MCLK; pins come straight from dbo_link_if
// Notes:   Pin synchronisers cost three cycles, so run lengths gate the park, rate and hold checks
`timescale 1ns/1ns
`default_nettype none
module dbo_link_properties #(
    parameter int CFG_LOAD_CYCLES = 50
) (
    input wire logic                      MCLK,
    input wire logic                      RST_B,
    input wire logic [dbo_pkg::SMP_W-1:0] bus_a,
    input wire logic [dbo_pkg::SMP_W-1:0] bus_b,
    input wire logic                      ready_strobe_a,
    input wire logic                      ready_strobe_b,
    input wire logic                      reload_n,
    input wire logic                      capture_sync_hold_n
);
    localparam int RESUME_MAX = CFG_LOAD_CYCLES + 12;
    logic [2:0] hi_cnt;
    logic [2:0] lo_cnt;
    logic [7:0] rl_cnt;
    logic [2:0] next_hi_cnt;
    logic [2:0] next_lo_cnt;
    logic [7:0] next_rl_cnt;
    logic       parked;
    assign parked = ready_strobe_a && ready_strobe_b && (bus_a == dbo_pkg::BUS_PARKED)
                    && (bus_b == dbo_pkg::BUS_PARKED);
    // Run lengths of the pins; saturating keeps long holds cheap
    always_comb begin
        next_hi_cnt = (capture_sync_hold_n && reload_n) ? hi_cnt + (hi_cnt != 3'h7) : 3'h0;
        next_lo_cnt = !capture_sync_hold_n ? lo_cnt + (lo_cnt != 3'h7) : 3'h0;
        next_rl_cnt = !reload_n ? rl_cnt + (rl_cnt != 8'hFF) : 8'h00;
    end
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            hi_cnt <= 3'h0;
            lo_cnt <= 3'h0;
            rl_cnt <= 8'h00;
        end else begin
            hi_cnt <= next_hi_cnt;
            lo_cnt <= next_lo_cnt;
            rl_cnt <= next_rl_cnt;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    a_strobes_paired: assert property (ready_strobe_a == ready_strobe_b)
        else $error("strobes differ");
    a_reload_parks: assert property (!reload_n && rl_cnt >= 8'h05 |-> parked)
        else $error("outputs not parked during reload");
    a_no_early_load: assert property ($rose(reload_n) |-> parked [*8])
        else $error("outputs left park too soon");
    a_reload_bounded: assert property ($rose(reload_n) && capture_sync_hold_n
        |-> ##[1:RESUME_MAX] $changed(ready_strobe_a)) else $error("strobes did not resume");
    a_reload_hold_len: assert property ($rose(reload_n) |-> rl_cnt == 8'h14)
        else $error("reload low time wrong");
    a_half_rate: assert property ($changed(ready_strobe_a) && hi_cnt >= 3'h5
        |=> $stable(ready_strobe_a) ##1 $changed(ready_strobe_a)) else $error("strobe rate");
    // Reload parking overrides the hold, so only a live link is checked
    a_hold_stops: assert property (lo_cnt >= 3'h6 && reload_n |-> $stable(ready_strobe_a))
        else $error("strobe moved while held");
    a_hold_resume: assert property ($rose(capture_sync_hold_n) && reload_n
        |-> ##[1:8] $changed(ready_strobe_a)) else $error("strobes did not restart");
    c_reload: cover property ($rose(reload_n));
    c_hold: cover property (lo_cnt == 3'h7);
    c_run: cover property ($changed(ready_strobe_a) && hi_cnt >= 3'h5);
endmodule
`default_nettype wire

// [sim/dbo_out_ctrl_test.sv]
// Purpose: Self-checking bench joining converter end and capture end
// Assumes: Short load and reload limit so every wait stays small
// Notes:   Samples count up each cycle outside the format test, so pair order shows in the words
`timescale 1ns/1ns
`default_nettype none
module dbo_out_ctrl_test;
    localparam int LOAD = 50;
    localparam int LIMIT = 200;
    localparam logic [11:0] ONES = dbo_pkg::BUS_PARKED;
    logic        MCLK = 1'b0;
    logic        RST_B = 1'b0;
    logic [11:0] smp = 12'h000;
    logic        fmt = 1'b1;
    logic        cnt_mode = 1'b1;
    logic        rl_req = 1'b0;
    logic        s_hold = 1'b0;
    logic [11:0] pa;
    logic [11:0] pb;
    logic        pv;
    logic        lup;
    logic        tmo;
    logic        cfg_rdy;
    int          n_errors = 0;
    int          checks = 0;
    dbo_link_if link ();
    dbo_out_ctrl #(.CFG_LOAD_CYCLES(LOAD)) i_dbo_out_ctrl (.MCLK(MCLK), .RST_B(RST_B),
        .SAMPLE_IN(smp), .FORMAT_OFFSET(fmt), .CFG_READY(cfg_rdy), .LINK(link.dev));
    dbo_capture #(.RELOAD_LIMIT_CYCLES(LIMIT)) i_dbo_capture (.MCLK(MCLK), .RST_B(RST_B),
        .RELOAD_REQ(rl_req), .SYNC_HOLD(s_hold), .PAIR_A(pa), .PAIR_B(pb), .PAIR_VALID(pv),
        .LINK_UP(lup), .RELOAD_TIMEOUT(tmo), .LINK(link.cap));
    dbo_link_properties #(.CFG_LOAD_CYCLES(LOAD)) i_dbo_link_properties (.MCLK(MCLK),
        .RST_B(RST_B), .bus_a(link.bus_a), .bus_b(link.bus_b),
        .ready_strobe_a(link.ready_strobe_a), .ready_strobe_b(link.ready_strobe_b),
        .reload_n(link.reload_n), .capture_sync_hold_n(link.capture_sync_hold_n));
    // Clock at 100 MHz
    always #5 MCLK = ~MCLK;
    // One conversion per cycle; a constant code makes the format visible
    always @(posedge MCLK) begin
        #1;
        smp <= cnt_mode ? smp + 12'h001 : 12'h123;
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    // Bounded wait for a flag; a lost handshake ends the run at once
    task automatic wait_hi(input string what, ref logic f, input int lim);
        int i;
        i = 0;
        do begin
            step(1);
            i++;
        end while (f !== 1'b1 && i < lim);
        chk(what, 12'h001, {11'h000, f});
        if (f !== 1'b1) end_sim();
    endtask
    task automatic chk_parked();
        chk("bus a parked", ONES, link.bus_a);
        chk("bus b parked", ONES, link.bus_b);
        chk("strobes parked", 12'h003, {10'h000, link.ready_strobe_a, link.ready_strobe_b});
    endtask
    // Counting samples: bus B one after bus A, next pair two later
    task automatic pair_run(input int n);
        logic [11:0] prev;
        wait_hi("pair", pv, 100);
        prev = pa;
        repeat (n) begin
            chk("bus b word", prev + 12'h001, pb);
            wait_hi("pair", pv, 100);
            chk("bus a step", prev + 12'h002, pa);
            prev = pa;
        end
    endtask
    task automatic t_power_up();
        chk_parked();
        chk("cfg ready", 12'h000, {11'h000, cfg_rdy});
        wait_hi("cfg ready", cfg_rdy, LOAD + 10);
        wait_hi("link up", lup, 20);
    endtask
    task automatic t_format();
        cnt_mode = 1'b0;
        for (int f = 0; f < 2; f++) begin
            fmt = f[0];
            step(10);
            wait_hi("pair", pv, 100);
            chk("bus a format", f ? 12'h123 : 12'h923, pa);
            chk("bus b format", f ? 12'h123 : 12'h923, pb);
        end
        cnt_mode = 1'b1;
    endtask
    task automatic t_sync_hold();
        logic st;
        s_hold = 1'b1;
        step(12);
        st = link.ready_strobe_a;
        repeat (10) begin
            chk("pair while held", 12'h000, {11'h000, pv});
            chk("strobe while held", {11'h000, st}, {11'h000, link.ready_strobe_a});
            step(1);
        end
        s_hold = 1'b0;
        pair_run(2);
    endtask
    task automatic t_reload();
        int i;
        rl_req = 1'b1;
        step(1);
        rl_req = 1'b0;
        i = 0;
        while (link.reload_n === 1'b0 && i < 40) begin
            i++;
            if (i == 8) chk_parked();
            step(1);
        end
        chk("reload low cycles", 12'h014, 12'(i));
        chk("link up in reload", 12'h000, {11'h000, lup});
        step(8);
        chk_parked();
        wait_hi("link up", lup, LOAD + 30);
        chk("no timeout", 12'h000, {11'h000, tmo});
        pair_run(2);
    endtask
    // Held strobes never resume, so the capture end must time out
    task automatic t_timeout();
        s_hold = 1'b1;
        step(12);
        rl_req = 1'b1;
        step(1);
        rl_req = 1'b0;
        wait_hi("timeout", tmo, LIMIT + 60);
        chk("link up held", 12'h000, {11'h000, lup});
        s_hold = 1'b0;
        wait_hi("link up", lup, 40);
        pair_run(1);
    endtask
    // Main sequence
    initial begin
        step(3);
        RST_B = 1'b1;
        t_power_up();
        pair_run(3);
        t_format();
        t_sync_hold();
        t_reload();
        t_timeout();
        end_sim();
    end
endmodule
`default_nettype wire
